// File: hw/utq_top.sv
// Completion queue, control registers, events and debug break handshake
//
// What this block does
// - Five-bit write pointer moved by hardware, five-bit read pointer moved for software.
// - Pointers hold negative values; entry address is table base plus twice pointer.
// - Queued entry count is read pointer minus write pointer.
// - Completed IN/OUT stores endpoint table address at base plus twice pointer, then decrements.
// - A pointer reaching the queue size wraps back to start.
// - Reading the read pointer decrements it if queue non-empty and no store that cycle; reading write pointer has no effect.
// - Transfer flag set while pointers differ or queue full, cleared when equal.
// - Ten interrupt sources on two vectors, gated by level and enables.
// - Transaction vector fed by transfer-complete and setup-complete flags.
// - Line-event vector fed by eight line and error sources.
// - Wake detection on a non-idle suspended bus works without a clock.
// - Event outputs for setup, frame start, check error, under/overflow.
// - Break mode off: debug break acknowledged at once.
// - Break mode on: acknowledge when idle, then refuse every transaction.
// - Bit 7 enables interface; clearing aborts current transaction.
// - Bit 6 selects low speed at zero, full speed at one.
// - Bit 5 enables queue; clearing disables it and frees its memory.
// - Bit 4 stores each received frame number into frame location.
// - Endpoints above highest-endpoint field are discarded.
// - Hold-pullup bit keeps pull-up in device reset; only RESETN or a line register write clears it.
// - Remote wake drives resume once bus suspended at least 5 ms.
// - Queue spans four bytes per endpoint, growing down below table base.
// - Global refuse refuses all but setup, with no memory traffic.
// - Attach enables pull-up on the line chosen by speed.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module utq_top #(
	parameter int WAKE_IDLE_CYC = utq_pkg::WAKE_IDLE_MS * utq_pkg::CLK_MHZ * 1000
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RESETN,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	input  wire logic        TRN_DONE,
	input  wire logic [15:0] TRN_EP_ADDR,
	input  wire logic        SETUP_DONE,
	input  wire logic        SOF_SEEN,
	input  wire logic [10:0] SOF_FRAME,
	input  wire logic        IDLE_3MS,
	input  wire logic        BUS_RESET_SEEN,
	input  wire logic        ISO_CRC_ERR,
	input  wire logic        IN_STARVED,
	input  wire logic        OUT_REJECTED,
	input  wire logic        HALT_SENT,
	input  wire logic        BUS_SUSPENDED,
	input  wire logic        LINE_ACTIVE,
	input  wire logic        TXN_BUSY,
	input  wire logic        DEV_IN_RESET,
	input  wire logic [3:0]  TOKEN_EP,
	input  wire logic        DBG_BREAK_REQ,
	output logic             DBG_BREAK_ACK,
	output logic             MEM_WE,
	output logic [15:0]      MEM_ADDR,
	output logic [15:0]      MEM_WDATA,
	output logic             EV_SETUP,
	output logic             EV_SOF,
	output logic             EV_CRC,
	output logic             EV_UNDER_OVER,
	output logic             IRQ_TRANSACTION_DONE,
	output logic             IRQ_LINE_EVENT,
	output logic [1:0]       IRQ_LEVEL,
	output logic             WAKE_ASYNC,
	output logic             USB_ENABLE,
	output logic             FULL_SPEED,
	output logic             ABORT_TXN,
	output logic             TOKEN_EP_OK,
	output logic             PULLUP_DP,
	output logic             PULLUP_DM,
	output logic             RESUME_DRIVE,
	output logic             REFUSE_NON_SETUP,
	output logic             REFUSE_ALL
);
	import utq_pkg::*;
	if (WAKE_IDLE_CYC < 1 || WAKE_IDLE_CYC >= 2 ** 20) begin : g_chk
		$error("WAKE_IDLE_CYC out of range");
	end
	typedef struct packed {
		logic [2:0]  ln;
		logic [7:0]  main;
		logic [7:0]  line;
		logic [15:0] base;
		logic [7:0]  irqa;
		logic [1:0]  irqb;
		logic        dbgm;
		logic [4:0]  wp;
		logic [4:0]  rp;
		logic        full;
		logic        awg;
		logic [5:0]  awi;
		logic        wg;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bv;
		logic [1:0]  br;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
		logic        mwe;
		logic [15:0] madr;
		logic [15:0] mdat;
		logic        fpend;
		logic [10:0] fval;
		logic [3:0]  ev;
		logic        abort;
		logic        ack;
		logic [19:0] scnt;
		logic        slong;
	} utq_st_type;
	utq_st_type s_reg;
	utq_st_type s_next;
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	logic [5:0] qsize;
	logic [4:0] qlow;
	logic [5:0] wofs;
	logic       nonempty;
	logic       qwrite;
	logic [4:0] wp_step;
	logic [4:0] rp_step;
	logic       do_w;
	logic       ar_go;
	logic [5:0] ari;
	utq_irq_if  ib ();

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	assign qsize = {{1'b0, s_reg.main[3:0]} + 5'h01, 1'b0};
	assign qlow = 5'(PTR_SPAN - qsize);
	assign wofs = PTR_SPAN - {1'b0, s_reg.wp};
	assign nonempty = (s_reg.wp != s_reg.rp) | s_reg.full;
	assign qwrite = TRN_DONE & s_reg.main[B_QON] & s_reg.main[B_EN] & ~s_reg.full;
	assign wp_step = (s_reg.wp == qlow) ? PTR_START : s_reg.wp - 5'h01;
	assign rp_step = (s_reg.rp == qlow) ? PTR_START : s_reg.rp - 5'h01;
	assign do_w = s_reg.awg & s_reg.wg & ~s_reg.bv;
	assign ar_go = ARVALID & ~s_reg.rv;
	assign ari = ARADDR[7:2];

	always_comb begin
		s_next = s_reg;
		s_next.ln = {s_reg.ln[1], s_reg.ln[0], LINE_ACTIVE};
		s_next.mwe = 1'b0;
		s_next.abort = 1'b0;
		s_next.ev = {ISO_CRC_ERR, IN_STARVED | OUT_REJECTED, SOF_SEEN, SETUP_DONE};
		ib.set = '0;
		ib.clr = '0;
		ib.set[F_TRN] = TRN_DONE;
		ib.set[F_SETUP] = SETUP_DONE;
		ib.set[F_SOF] = SOF_SEEN;
		ib.set[F_IDLE] = IDLE_3MS;
		ib.set[F_WAKE] = s_reg.ln[1] & ~s_reg.ln[2] & BUS_SUSPENDED;
		ib.set[F_RST] = BUS_RESET_SEEN;
		ib.set[F_CRC] = ISO_CRC_ERR;
		ib.set[F_UNF] = IN_STARVED;
		ib.set[F_OVF] = OUT_REJECTED;
		ib.set[F_STALL] = HALT_SENT;
		// Queue store has the memory port; a frame number waits a cycle
		if (qwrite) begin
			s_next.mwe = 1'b1;
			s_next.madr = s_reg.base - {9'h000, wofs, 1'b0};
			s_next.mdat = TRN_EP_ADDR;
			s_next.wp = wp_step;
			s_next.full = (wp_step == s_reg.rp);
		end else if (s_reg.fpend) begin
			s_next.mwe = 1'b1;
			s_next.madr = s_reg.base - (s_reg.main[B_QON] ? {9'h000, qsize, 1'b0} : 16'h0000)
				- 16'h0002;
			s_next.mdat = {5'h00, s_reg.fval};
			s_next.fpend = 1'b0;
		end
		if (SOF_SEEN & s_reg.main[B_FRM]) begin
			s_next.fpend = 1'b1;
			s_next.fval = SOF_FRAME;
		end
		// Debug break handshake
		s_next.ack = DBG_BREAK_REQ & (s_reg.ack | ~s_reg.dbgm | ~TXN_BUSY);
		// Suspend time for remote wake
		if (!BUS_SUSPENDED) begin
			s_next.scnt = '0;
			s_next.slong = 1'b0;
			s_next.line[B_RWK] = 1'b0;
		end else if (s_reg.scnt == 20'(WAKE_IDLE_CYC - 1)) begin
			s_next.slong = 1'b1;
		end else begin
			s_next.scnt = s_reg.scnt + 20'h00001;
		end
		// Write channel capture
		if (AWVALID & ~s_reg.awg & ~s_reg.bv) begin
			s_next.awg = 1'b1;
			s_next.awi = AWADDR[7:2];
		end
		if (WVALID & ~s_reg.wg & ~s_reg.bv) begin
			s_next.wg = 1'b1;
			s_next.wd = WDATA;
			s_next.ws = WSTRB;
		end
		if (s_reg.bv & BREADY) begin
			s_next.bv = 1'b0;
		end
		if (do_w) begin
			s_next.awg = 1'b0;
			s_next.wg = 1'b0;
			s_next.bv = 1'b1;
			s_next.br = RESP_OKAY;
			if (s_reg.awi == IDX_MAIN) begin
				if (s_reg.ws[0]) begin
					s_next.main = s_reg.wd[7:0];
					s_next.abort = s_reg.main[B_EN] & ~s_reg.wd[B_EN];
				end
			end else if (s_reg.awi == IDX_LINE) begin
				if (s_reg.ws[0]) begin
					s_next.line = s_reg.wd[7:0] & LINE_MASK;
				end
			end else if (s_reg.awi == IDX_IRQA) begin
				if (s_reg.ws[0]) begin
					s_next.irqa = s_reg.wd[7:0] & IRQA_MASK;
				end
			end else if (s_reg.awi == IDX_IRQB) begin
				if (s_reg.ws[0]) begin
					s_next.irqb = s_reg.wd[1:0];
				end
			end else if (s_reg.awi == IDX_WP || s_reg.awi == IDX_RP) begin
				s_next.wp = PTR_START;
				s_next.rp = PTR_START;
				s_next.full = 1'b0;
			end else if (s_reg.awi == IDX_BASE) begin
				if (s_reg.ws[0]) begin
					s_next.base[7:0] = {s_reg.wd[7:1], 1'b0};
				end
				if (s_reg.ws[1]) begin
					s_next.base[15:8] = s_reg.wd[15:8];
				end
			end else if (s_reg.awi == IDX_FLAGS) begin
				ib.clr = s_reg.wd[9:0] & {{2{s_reg.ws[1]}}, {8{s_reg.ws[0]}}};
			end else if (s_reg.awi == IDX_DBG) begin
				if (s_reg.ws[0]) begin
					s_next.dbgm = s_reg.wd[0];
				end
			end else begin
				s_next.br = RESP_SLVERR;
			end
		end
		// Read channel
		if (s_reg.rv & RREADY) begin
			s_next.rv = 1'b0;
		end
		if (ar_go) begin
			s_next.rv = 1'b1;
			s_next.rr = RESP_OKAY;
			s_next.rd = '0;
			if (ari == IDX_MAIN) begin
				s_next.rd[7:0] = s_reg.main;
			end else if (ari == IDX_LINE) begin
				s_next.rd[7:0] = s_reg.line;
			end else if (ari == IDX_IRQA) begin
				s_next.rd[7:0] = s_reg.irqa;
			end else if (ari == IDX_IRQB) begin
				s_next.rd[1:0] = s_reg.irqb;
			end else if (ari == IDX_WP) begin
				s_next.rd[4:0] = s_reg.wp;
			end else if (ari == IDX_RP) begin
				s_next.rd[4:0] = s_reg.rp;
				if (nonempty & ~qwrite) begin
					s_next.rp = rp_step;
					s_next.full = 1'b0;
				end
			end else if (ari == IDX_BASE) begin
				s_next.rd[15:0] = s_reg.base;
			end else if (ari == IDX_FLAGS) begin
				s_next.rd[9:0] = ib.flags;
			end else if (ari == IDX_DBG) begin
				s_next.rd[0] = s_reg.dbgm;
			end else begin
				s_next.rr = RESP_SLVERR;
			end
		end
		if (!s_reg.main[B_QON]) begin
			s_next.wp = PTR_START;
			s_next.rp = PTR_START;
			s_next.full = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.wp <= PTR_START;
			s_reg.rp <= PTR_START;
		end else begin
			s_reg <= s_next;
		end
	end

	assign ib.qmode = s_reg.main[B_QON];
	assign ib.qlevel = nonempty;
	assign ib.irqa = s_reg.irqa;
	assign ib.irqb = s_reg.irqb;
	utq_irq u_irq (
		.clk   (CLK_SYS),
		.rst_n (rst_n),
		.bus   (ib)
	);

	assign AWREADY = ~s_reg.awg & ~s_reg.bv;
	assign WREADY = ~s_reg.wg & ~s_reg.bv;
	assign BVALID = s_reg.bv;
	assign BRESP = s_reg.br;
	assign ARREADY = ~s_reg.rv;
	assign RVALID = s_reg.rv;
	assign RDATA = s_reg.rd;
	assign RRESP = s_reg.rr;
	assign MEM_WE = s_reg.mwe;
	assign MEM_ADDR = s_reg.madr;
	assign MEM_WDATA = s_reg.mdat;
	assign {EV_CRC, EV_UNDER_OVER, EV_SOF, EV_SETUP} = s_reg.ev;
	assign IRQ_TRANSACTION_DONE = ib.vec_trn;
	assign IRQ_LINE_EVENT = ib.vec_bus;
	assign IRQ_LEVEL = s_reg.irqa[1:0];
	assign WAKE_ASYNC = LINE_ACTIVE & BUS_SUSPENDED;
	assign USB_ENABLE = s_reg.main[B_EN];
	assign ABORT_TXN = s_reg.abort;
	assign FULL_SPEED = s_reg.main[B_SPD];
	assign TOKEN_EP_OK = TOKEN_EP <= s_reg.main[3:0];
	assign PULLUP_DP = s_reg.line[B_ATT] & s_reg.main[B_SPD]
		& (~DEV_IN_RESET | s_reg.line[B_HOLD]);
	assign PULLUP_DM = s_reg.line[B_ATT] & ~s_reg.main[B_SPD]
		& (~DEV_IN_RESET | s_reg.line[B_HOLD]);
	assign RESUME_DRIVE = s_reg.line[B_RWK] & s_reg.slong & BUS_SUSPENDED;
	assign REFUSE_NON_SETUP = s_reg.line[B_REF];
	assign REFUSE_ALL = s_reg.dbgm & s_reg.ack;
	assign DBG_BREAK_ACK = s_reg.ack;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!rst_n);
	a_queue_store: assert property (qwrite |=> MEM_WE && MEM_ADDR == $past(s_reg.base)
		- {9'h000, $past(wofs), 1'b0} && s_reg.wp == $past(wp_step))
		else $error("queue store wrong");
	a_rp_read_step: assert property (ar_go && ari == IDX_RP && nonempty && !qwrite
		&& s_reg.main[B_QON] |=> s_reg.rp == $past(rp_step)) else $error("read pointer stuck");
	a_wp_read_calm: assert property (ar_go && ari == IDX_WP && !qwrite && s_reg.main[B_QON]
		|=> $stable(s_reg.wp)) else $error("write pointer moved on read");
	a_abort_pulse: assert property (do_w && s_reg.awi == IDX_MAIN && s_reg.ws[0]
		&& s_reg.main[B_EN] && !s_reg.wd[B_EN] |=> ABORT_TXN ##1 !ABORT_TXN)
		else $error("no abort on disable");
	a_break_free: assert property (!s_reg.dbgm && DBG_BREAK_REQ |=> DBG_BREAK_ACK)
		else $error("break not acknowledged");
	a_break_wait: assert property (s_reg.dbgm && TXN_BUSY && !DBG_BREAK_ACK |=> !DBG_BREAK_ACK)
		else $error("break acknowledged mid transaction");
	a_resume_gate: assert property (RESUME_DRIVE |-> BUS_SUSPENDED
		&& s_reg.scnt == 20'(WAKE_IDLE_CYC - 1)) else $error("resume too early");
	a_write_resp: assert property (s_reg.awg && s_reg.wg && !s_reg.bv |=> BVALID)
		else $error("write response missing");
	c_queue_full: cover property (s_reg.full);
	c_rp_pop: cover property (ar_go && ari == IDX_RP && nonempty);
	c_refuse: cover property (REFUSE_ALL);
endmodule // utq_top

// File: hw/utq_pkg.sv
// Constants shared by the completion queue and interrupt logic
package utq_pkg;
	localparam int unsigned CLK_MHZ      = 200;
	localparam int unsigned WAKE_IDLE_MS = 5;
	localparam logic [5:0] IDX_MAIN  = 6'h00;
	localparam logic [5:0] IDX_LINE  = 6'h01;
	localparam logic [5:0] IDX_IRQA  = 6'h06;
	localparam logic [5:0] IDX_IRQB  = 6'h07;
	localparam logic [5:0] IDX_WP    = 6'h10;
	localparam logic [5:0] IDX_RP    = 6'h11;
	localparam logic [5:0] IDX_BASE  = 6'h12;
	localparam logic [5:0] IDX_FLAGS = 6'h13;
	localparam logic [5:0] IDX_DBG   = 6'h14;
	localparam int B_EN = 7;
	localparam int B_SPD = 6;
	localparam int B_QON = 5;
	localparam int B_FRM = 4;
	localparam int B_HOLD = 4;
	localparam int B_RWK = 2;
	localparam int B_REF = 1;
	localparam int B_ATT = 0;
	localparam logic [7:0] LINE_MASK = 8'h17;
	localparam logic [7:0] IRQA_MASK = 8'hf3;
	localparam int B_SOFIE = 7;
	localparam int B_BUSEVIE = 6;
	localparam int B_BUSERRIE = 5;
	localparam int B_STALLIE = 4;
	localparam int B_TRNIE = 1;
	localparam int B_SETUPIE = 0;
	localparam int F_TRN = 0;
	localparam int F_SETUP = 1;
	localparam int F_SOF = 2;
	localparam int F_IDLE = 3;
	localparam int F_WAKE = 4;
	localparam int F_RST = 5;
	localparam int F_CRC = 6;
	localparam int F_UNF = 7;
	localparam int F_OVF = 8;
	localparam int F_STALL = 9;
	localparam logic [4:0] PTR_START = 5'h1f;
	localparam logic [5:0] PTR_SPAN = 6'd32;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: hw/utq_irq_if.sv
// Flag and enable signals between the control core and the interrupt unit
`timescale 1ns/1ps
interface utq_irq_if;
	logic [9:0] set;
	logic [9:0] clr;
	logic       qmode;
	logic       qlevel;
	logic [7:0] irqa;
	logic [1:0] irqb;
	logic [9:0] flags;
	logic       vec_trn;
	logic       vec_bus;
	modport core (output set, clr, qmode, qlevel, irqa, irqb, input flags, vec_trn, vec_bus);
	modport irq (input set, clr, qmode, qlevel, irqa, irqb, output flags, vec_trn, vec_bus);
endinterface

// File: hw/utq_irq.sv
// Sticky interrupt flags and the two gated interrupt vectors
`timescale 1ns/1ps
module utq_irq (
	input wire logic clk,
	input wire logic rst_n,
	utq_irq_if.irq   bus
);
	import utq_pkg::*;
	typedef struct packed {
		logic [9:0] flags;
	} utq_irq_st_type;
	utq_irq_st_type s_reg;
	utq_irq_st_type s_next;
	logic lvl_on;
	always_comb begin
		s_next = s_reg;
		s_next.flags = (s_reg.flags & ~bus.clr) | bus.set;
		if (bus.qmode) begin
			s_next.flags[F_TRN] = bus.qlevel;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign lvl_on = |bus.irqa[1:0];
	assign bus.flags = s_reg.flags;
	assign bus.vec_trn = lvl_on & ((s_reg.flags[F_TRN] & bus.irqb[B_TRNIE])
		| (s_reg.flags[F_SETUP] & bus.irqb[B_SETUPIE]));
	assign bus.vec_bus = lvl_on & ((s_reg.flags[F_SOF] & bus.irqa[B_SOFIE])
		| (|s_reg.flags[F_RST:F_IDLE] & bus.irqa[B_BUSEVIE])
		| (|s_reg.flags[F_OVF:F_CRC] & bus.irqa[B_BUSERRIE])
		| (s_reg.flags[F_STALL] & bus.irqa[B_STALLIE]));

	a_set_beats_clr: assert property (@(posedge clk) disable iff (!rst_n)
		bus.set[F_SETUP] |=> s_reg.flags[F_SETUP]) else $error("setup flag lost");
	a_level_gates: assert property (@(posedge clk) disable iff (!rst_n)
		bus.irqa[1:0] == 2'b00 |-> !bus.vec_trn && !bus.vec_bus)
		else $error("vector without level");
	a_trn_follows_q: assert property (@(posedge clk) disable iff (!rst_n)
		bus.qmode |=> s_reg.flags[F_TRN] == $past(bus.qlevel))
		else $error("transfer flag not tracking queue");
	c_bus_vec: cover property (@(posedge clk) disable iff (!rst_n) bus.vec_bus);
endmodule // utq_irq

// File: sim/utq_host_model.sv
// Packet-engine side model driving completion and line event pulses
`timescale 1ns/1ps
module utq_host_model (
	input  wire logic   clk,
	output logic [8:0]  pulse,
	output logic [15:0] ep_addr,
	output logic [10:0] frame
);
	initial begin
		pulse = 9'h000;
		ep_addr = 16'h0000;
		frame = 11'h000;
	end
	// Bits: completion, setup, sof, idle, reset, crc, starved, rejected, halt
	task automatic fire(input int i, input logic [15:0] a);
		@(posedge clk);
		pulse[i] <= 1'b1;
		ep_addr <= a;
		frame <= a[10:0];
		@(posedge clk);
		pulse[i] <= 1'b0;
		ep_addr <= ~a;
		frame <= ~a[10:0];
	endtask
endmodule // utq_host_model

// File: sim/utq_top_tb.sv
// Self-checking bench for the completion queue and control block
`timescale 1ns/1ps
module utq_top_tb;
	import utq_pkg::*;
	logic        CLK_SYS, RESETN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic        ARVALID, ARREADY, RVALID, RREADY, BUS_SUSPENDED, LINE_ACTIVE;
	logic        TXN_BUSY, DEV_IN_RESET, DBG_BREAK_REQ, DBG_BREAK_ACK, MEM_WE, ABORT_TXN;
	logic        EV_SETUP, EV_SOF, EV_CRC, EV_UNDER_OVER, IRQ_TRANSACTION_DONE;
	logic        IRQ_LINE_EVENT, WAKE_ASYNC, USB_ENABLE, FULL_SPEED, TOKEN_EP_OK;
	logic        PULLUP_DP, PULLUP_DM, RESUME_DRIVE, REFUSE_NON_SETUP, REFUSE_ALL;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rd;
	logic [3:0]  WSTRB, TOKEN_EP;
	logic [1:0]  BRESP, RRESP, IRQ_LEVEL, rs;
	logic [15:0] MEM_ADDR, MEM_WDATA, ep_addr, we_addr, we_data;
	logic [10:0] frame;
	logic [8:0]  pulse;
	int          fail_count, cmp_count, cyc, ev_sof, ev_uo, ev_set, ev_crc;
	utq_host_model host (.clk(CLK_SYS), .pulse(pulse), .ep_addr(ep_addr), .frame(frame));
	utq_top #(.WAKE_IDLE_CYC(8)) dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
		.WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .TRN_DONE(pulse[0]), .TRN_EP_ADDR(ep_addr),
		.SETUP_DONE(pulse[1]), .SOF_SEEN(pulse[2]), .SOF_FRAME(frame),
		.IDLE_3MS(pulse[3]), .BUS_RESET_SEEN(pulse[4]), .ISO_CRC_ERR(pulse[5]),
		.IN_STARVED(pulse[6]), .OUT_REJECTED(pulse[7]), .HALT_SENT(pulse[8]),
		.BUS_SUSPENDED(BUS_SUSPENDED), .LINE_ACTIVE(LINE_ACTIVE),
		.TXN_BUSY(TXN_BUSY), .DEV_IN_RESET(DEV_IN_RESET), .TOKEN_EP(TOKEN_EP),
		.DBG_BREAK_REQ(DBG_BREAK_REQ), .DBG_BREAK_ACK(DBG_BREAK_ACK),
		.MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
		.EV_SETUP(EV_SETUP), .EV_SOF(EV_SOF), .EV_CRC(EV_CRC),
		.EV_UNDER_OVER(EV_UNDER_OVER), .IRQ_TRANSACTION_DONE(IRQ_TRANSACTION_DONE),
		.IRQ_LINE_EVENT(IRQ_LINE_EVENT), .IRQ_LEVEL(IRQ_LEVEL),
		.WAKE_ASYNC(WAKE_ASYNC), .USB_ENABLE(USB_ENABLE), .FULL_SPEED(FULL_SPEED),
		.ABORT_TXN(ABORT_TXN), .TOKEN_EP_OK(TOKEN_EP_OK), .PULLUP_DP(PULLUP_DP),
		.PULLUP_DM(PULLUP_DM), .RESUME_DRIVE(RESUME_DRIVE),
		.REFUSE_NON_SETUP(REFUSE_NON_SETUP), .REFUSE_ALL(REFUSE_ALL));
	initial begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end
	// Cycle limit and output pulse monitors
	always @(posedge CLK_SYS) begin
		if (MEM_WE === 1'b1) begin
			we_addr <= MEM_ADDR;
			we_data <= MEM_WDATA;
		end
		if (EV_SOF === 1'b1) ev_sof <= ev_sof + 1;
		if (EV_UNDER_OVER === 1'b1) ev_uo <= ev_uo + 1;
		if (EV_SETUP === 1'b1) ev_set <= ev_set + 1;
		if (EV_CRC === 1'b1) ev_crc <= ev_crc + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", n, exp, seen);
			fail_count++;
		end
	endtask
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask
	// Reserved bits are always written as zero
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic b;
		b = 1'b0;
		AWADDR <= a;
		WDATA <= d;
		WSTRB <= 4'hf;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		while (!b) begin
			@(posedge CLK_SYS);
			if (AWVALID && AWREADY) AWVALID <= 1'b0;
			if (WVALID && WREADY) WVALID <= 1'b0;
			b = BVALID;
			rs = BRESP;
		end
		chk("bresp", rs, er);
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] er);
		logic t;
		t = 1'b0;
		ARADDR <= a;
		ARVALID <= 1'b1;
		while (!t) begin
			@(posedge CLK_SYS);
			if (ARVALID && ARREADY) ARVALID <= 1'b0;
			t = RVALID;
			rd = RDATA;
			rs = RRESP;
		end
		chk("rresp", rs, er);
	endtask
	task automatic t_regs();
		axr(8'h00, RESP_OKAY);
		chk("main reset", rd, 32'h0);
		axr(8'h04, RESP_OKAY);
		chk("line reset", rd, 32'h0);
		axr(8'h40, RESP_OKAY);
		chk("wp reset", rd, 32'h1f);
		axr(8'h3c, RESP_SLVERR);
		axw(8'h3c, 32'h1, RESP_SLVERR);
		axw(8'h00, 32'hc0, RESP_OKAY);
		chk("full speed", FULL_SPEED, 1'b1);
		chk("enable", USB_ENABLE, 1'b1);
		axw(8'h00, 32'h80, RESP_OKAY);
		chk("low speed", FULL_SPEED, 1'b0);
		chk("no abort", ABORT_TXN, 1'b0);
		axw(8'h04, 32'h03, RESP_OKAY);
		chk("refuse", REFUSE_NON_SETUP, 1'b1);
		chk("pull dm", PULLUP_DM, 1'b1);
		chk("pull dp", PULLUP_DP, 1'b0);
		DEV_IN_RESET <= 1'b1;
		cyc_wait(1);
		chk("reset pull", PULLUP_DM, 1'b0);
		axw(8'h04, 32'h13, RESP_OKAY);
		chk("hold pull", PULLUP_DM, 1'b1);
		DEV_IN_RESET <= 1'b0;
		axw(8'h00, 32'h00, RESP_OKAY);
		chk("abort", ABORT_TXN, 1'b1);
		chk("disable", USB_ENABLE, 1'b0);
	endtask
	task automatic t_queue();
		axw(8'h00, 32'ha3, RESP_OKAY);
		axw(8'h48, 32'h0100, RESP_OKAY);
		host.fire(0, 16'h0140);
		cyc_wait(3);
		chk("store addr", we_addr, 16'h00fe);
		chk("store data", we_data, 16'h0140);
		axr(8'h40, RESP_OKAY);
		chk("wp step", rd, 32'h1e);
		axr(8'h4c, RESP_OKAY);
		chk("flag on", rd[0], 1'b1);
		host.fire(0, 16'h0150);
		cyc_wait(3);
		chk("store addr2", we_addr, 16'h00fc);
		axr(8'h44, RESP_OKAY);
		chk("rp pop1", rd, 32'h1f);
		axr(8'h44, RESP_OKAY);
		chk("rp pop2", rd, 32'h1e);
		axr(8'h4c, RESP_OKAY);
		chk("flag off", rd[0], 1'b0);
		axr(8'h40, RESP_OKAY);
		chk("wp kept", rd, 32'h1d);
		TOKEN_EP <= 4'h4;
		cyc_wait(1);
		chk("ep high", TOKEN_EP_OK, 1'b0);
		TOKEN_EP <= 4'h3;
		cyc_wait(1);
		chk("ep ok", TOKEN_EP_OK, 1'b1);
	endtask
	task automatic t_irq();
		axw(8'h00, 32'h90, RESP_OKAY);
		axw(8'h18, 32'h81, RESP_OKAY);
		host.fire(2, 16'h0123);
		cyc_wait(4);
		chk("frame addr", we_addr, 16'h00fe);
		chk("frame data", we_data, 16'h0123);
		chk("sof irq", IRQ_LINE_EVENT, 1'b1);
		chk("level", IRQ_LEVEL, 2'h1);
		chk("sof event", ev_sof, 1);
		axw(8'h18, 32'h80, RESP_OKAY);
		chk("level off", IRQ_LINE_EVENT, 1'b0);
		axw(8'h4c, 32'h004, RESP_OKAY);
		axw(8'h18, 32'h81, RESP_OKAY);
		chk("flag clr", IRQ_LINE_EVENT, 1'b0);
		host.fire(5, 16'h0);
		host.fire(6, 16'h0);
		host.fire(7, 16'h0);
		cyc_wait(3);
		chk("uo event", ev_uo, 2);
		chk("crc event", ev_crc, 1);
		chk("masked", IRQ_LINE_EVENT, 1'b0);
		axw(8'h1c, 32'h01, RESP_OKAY);
		host.fire(1, 16'h0);
		cyc_wait(3);
		chk("setup irq", IRQ_TRANSACTION_DONE, 1'b1);
		chk("setup event", ev_set, 1);
		axw(8'h1c, 32'h02, RESP_OKAY);
		chk("setup off", IRQ_TRANSACTION_DONE, 1'b0);
		host.fire(0, 16'h0);
		cyc_wait(3);
		chk("trn irq", IRQ_TRANSACTION_DONE, 1'b1);
	endtask
	task automatic t_dbg();
		DBG_BREAK_REQ <= 1'b1;
		cyc_wait(2);
		chk("ack now", DBG_BREAK_ACK, 1'b1);
		DBG_BREAK_REQ <= 1'b0;
		axw(8'h50, 32'h1, RESP_OKAY);
		TXN_BUSY <= 1'b1;
		DBG_BREAK_REQ <= 1'b1;
		cyc_wait(5);
		chk("ack held", DBG_BREAK_ACK, 1'b0);
		TXN_BUSY <= 1'b0;
		cyc_wait(3);
		chk("ack idle", DBG_BREAK_ACK, 1'b1);
		chk("refuse all", REFUSE_ALL, 1'b1);
		DBG_BREAK_REQ <= 1'b0;
	endtask
	task automatic t_wake();
		BUS_SUSPENDED <= 1'b1;
		cyc_wait(12);
		axw(8'h04, 32'h05, RESP_OKAY);
		cyc_wait(4);
		chk("resume", RESUME_DRIVE, 1'b1);
		LINE_ACTIVE <= 1'b1;
		cyc_wait(1);
		chk("wake", WAKE_ASYNC, 1'b1);
		cyc_wait(3);
		axr(8'h4c, RESP_OKAY);
		chk("wake flag", rd[4], 1'b1);
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h05;
		{BUS_SUSPENDED, LINE_ACTIVE, TXN_BUSY, DEV_IN_RESET, DBG_BREAK_REQ} = 5'h00;
		AWADDR = 8'h00;
		ARADDR = 8'h00;
		WDATA = 32'h0;
		WSTRB = 4'h0;
		TOKEN_EP = 4'h0;
		{fail_count, cmp_count, cyc, ev_sof, ev_uo, ev_set, ev_crc} = '0;
		RESETN = 1'b0;
		repeat (10) @(posedge CLK_SYS);
		RESETN <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		t_regs();
		t_queue();
		t_irq();
		t_dbg();
		t_wake();
		finish_test();
	end
endmodule // utq_top_tb
